// ==== common/elc_pkg.sv ====
// Purpose: constants and types for the LED enhancement block
// Assumes: 10 MHz core clock, AHB-Lite register access, 32-bit data
// Notes:   register indices are word indices; byte address is index times four
package elc_pkg;

    // clock
    localparam int unsigned CLK_PERIOD_NS = 100;

    // register indices and byte addresses
    localparam logic [7:0]  LEC_IDX   = 8'h19;          // led_enhancement_control
    localparam logic [7:0]  STAT_IDX  = 8'h1A;          // block status
    localparam logic [7:0]  PCTL_IDX  = 8'h1E;          // pulsing control
    localparam logic [9:0]  LEC_ADDR  = {LEC_IDX, 2'b00};
    localparam logic [9:0]  STAT_ADDR = {STAT_IDX, 2'b00};
    localparam logic [9:0]  PCTL_ADDR = {PCTL_IDX, 2'b00};

    // field positions
    localparam int unsigned DUTY_LSB     = 8;
    localparam int unsigned P1_EN_BIT    = 7;
    localparam int unsigned P0_EN_BIT    = 6;
    localparam int unsigned RATE_LSB     = 3;
    localparam int unsigned SEL_LSB      = 1;
    localparam int unsigned PULSE_EN_BIT = 12;

    // values after reset
    localparam logic [15:0] LEC_RST  = 16'h0000;
    localparam logic        PCTL_RST = 1'h0;

    // pulsing
    localparam logic [7:0]  DUTY_MAX        = 8'hC6;    // 198
    localparam int unsigned SLICES          = 200;
    localparam int unsigned PULSE_PERIOD_NS = 5000000;
    localparam int unsigned SLICE_CYC       = PULSE_PERIOD_NS / CLK_PERIOD_NS / SLICES;

    // serial stream
    localparam logic [2:0]  RATE_BASIC   = 3'h7;
    localparam int unsigned SER_HALF_NS  = 1000;
    localparam int unsigned SER_HALF_CYC = SER_HALF_NS / CLK_PERIOD_NS;
    localparam int unsigned FRM_HZ [0:6] = '{2500, 1000, 500, 250, 200, 125, 40};

    function automatic int unsigned frm_cyc(input int unsigned hz);
        return 1000000000 / (hz * CLK_PERIOD_NS);
    endfunction : frm_cyc

    localparam int unsigned FRM_CYC_DEF [0:6] = '{frm_cyc(FRM_HZ[0]), frm_cyc(FRM_HZ[1]),
        frm_cyc(FRM_HZ[2]), frm_cyc(FRM_HZ[3]), frm_cyc(FRM_HZ[4]), frm_cyc(FRM_HZ[5]),
        frm_cyc(FRM_HZ[6])};

    // buffering
    localparam int unsigned FIFO_DEPTH = 16;

    // one snapshot of both PHYs' LEDs
    typedef struct packed {
        logic [3:0] p1;
        logic [3:0] p0;
    } elc_leds_t;

    // serial pin group
    typedef struct packed {
        logic load;
        logic clk;
        logic data;
    } elc_ser_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_LOAD  = 3'b100
    } elc_ser_st_t;

endpackage : elc_pkg

// ==== core/elc_top.sv ====
// Purpose: LED pulsing and enhanced serial LED output with AHB-Lite registers
// Assumes: LED inputs come from logic on clk_i; zero-wait-state slave
// Notes:   snapshots pass a FIFO so a slow serial shifter can stall capture
`timescale 1ns/1ps

module elc_fifo #(
    parameter int unsigned W  = 8,
    parameter int unsigned D  = 16,
    localparam int unsigned AW = $clog2(D)
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    // filling side
    input  wire logic          in_valid_i,
    output logic               in_ready_o,
    input  wire logic [W-1:0]  in_data_i,
    // draining side
    output logic               out_valid_o,
    input  wire logic          out_ready_i,
    output logic [W-1:0]       out_data_o,
    output logic [AW:0]        count_o
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wr;
        logic [AW:0]         rd;
    } elc_fifo_st_t;

    elc_fifo_st_t s_reg;
    elc_fifo_st_t s_next;

    // flags come from pointer distance, the extra bit tells full from empty
    assign count_o     = s_reg.wr - s_reg.rd;
    assign in_ready_o  = (count_o != (AW+1)'(D));
    assign out_valid_o = (count_o != '0);
    assign out_data_o  = s_reg.mem[s_reg.rd[AW-1:0]];

    always_comb begin
        s_next = s_reg;
        if (in_valid_i && in_ready_o) begin
            s_next.mem[s_reg.wr[AW-1:0]] = in_data_i;
            s_next.wr                   = s_reg.wr + 1'b1;
        end
        if (out_valid_o && out_ready_i) begin
            s_next.rd = s_reg.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : elc_fifo

// Overview of operation
// - duty setting 0..198 in upper byte
// - setting 0 gives 0.5%, 198 gives 99.5%
// - each step adds 0.5% on-time
// - duty pulsing only while pulsing enable set
// - bit 7 puts serial output on port 1
// - bit 6 puts serial output on port 0
// - bits 5:3 pick frame rate 2500..40 Hz
// - code 111 sends basic serial stream
// - bits 2:1 pick LEDs per PHY in stream, except code 111, which sends all four
module elc_top #(
    parameter int unsigned FRM_CYC [0:6] = elc_pkg::FRM_CYC_DEF
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // led indications from the phys
    input  wire logic [3:0]  led_p0_i,
    input  wire logic [3:0]  led_p1_i,
    // led pins
    output logic      [3:0]  led_p0_o,
    output logic      [3:0]  led_p1_o
);
    typedef struct packed {
        logic [15:0]          lec;
        logic                 pulse_en;
        logic                 dp_write;
        logic [9:0]           dp_addr;
        logic [31:0]          rdata;
        logic [7:0]           slice_div;
        logic [7:0]           slice_cnt;
        logic [19:0]          frm_cnt;
        logic                 pend;
        elc_pkg::elc_leds_t   snap;
        elc_pkg::elc_ser_st_t st;
        logic [3:0]           half_cnt;
        logic [7:0]           shreg;
        logic [3:0]           bits_left;
        elc_pkg::elc_ser_t    ser;
        logic [3:0]           p0_out;
        logic [3:0]           p1_out;
    } elc_state_t;

    elc_state_t s_reg;
    elc_state_t s_next;

    // decoded register fields
    logic [7:0]          duty;
    logic [7:0]          duty_eff;
    logic [2:0]          rate;
    logic [1:0]          sel;
    logic                p0_ser;
    logic                p1_ser;
    logic                pulse_on;
    logic                addr_ok;
    logic                tick;
    logic                half_end;
    logic                pop;
    int unsigned         period;
    // fifo wires
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    elc_pkg::elc_leds_t  fifo_out;
    logic [4:0]          fifo_count;

    assign duty   = s_reg.lec[elc_pkg::DUTY_LSB +: 8];
    assign rate   = s_reg.lec[elc_pkg::RATE_LSB +: 3];
    assign sel    = s_reg.lec[elc_pkg::SEL_LSB +: 2];
    assign p0_ser = s_reg.lec[elc_pkg::P0_EN_BIT];
    assign p1_ser = s_reg.lec[elc_pkg::P1_EN_BIT];

    // codes past 198 are clamped so the led never stays fully on
    assign duty_eff = (duty > elc_pkg::DUTY_MAX) ? elc_pkg::DUTY_MAX : duty;
    // slices 0..duty are on: duty+1 of 200 slices, 0.5% each
    assign pulse_on = (s_reg.slice_cnt <= duty_eff);

    // basic stream runs at the fastest frame period
    assign period   = (rate == elc_pkg::RATE_BASIC) ? FRM_CYC[0] : FRM_CYC[rate];
    assign tick     = (32'(s_reg.frm_cnt) + 32'd1 >= period);
    assign half_end = (s_reg.half_cnt == 4'(elc_pkg::SER_HALF_CYC - 1));
    assign pop      = (s_reg.st == elc_pkg::ST_IDLE) && fifo_out_valid;

    // aligned whole-word access inside the block's address window
    assign addr_ok     = (haddr_i[31:10] == 22'h000000) && (hsize_i == 3'h2);
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = s_reg.rdata;
    assign led_p0_o    = s_reg.p0_out;
    assign led_p1_o    = s_reg.p1_out;

    elc_fifo #(
        .W (8),
        .D (elc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (s_reg.pend),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (s_reg.snap),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_out),
        .count_o     (fifo_count)
    );

    // register access, pulse timer, frame timer and serial shifter
    always_comb begin
        s_next = s_reg;
        // data phase: write lands one cycle after its address phase
        if (s_reg.dp_write) begin
            if (s_reg.dp_addr == elc_pkg::LEC_ADDR) begin
                s_next.lec = hwdata_i[15:0];
            end else if (s_reg.dp_addr == elc_pkg::PCTL_ADDR) begin
                s_next.pulse_en = hwdata_i[elc_pkg::PULSE_EN_BIT];
            end
        end
        s_next.dp_write = 1'b0;
        // address phase: read data built from post-write values
        if (hsel_i && htrans_i[1] && hready_i) begin
            s_next.dp_write = hwrite_i && addr_ok;
            s_next.dp_addr  = haddr_i[9:0];
            s_next.rdata    = 32'h00000000;
            if (!hwrite_i && addr_ok) begin
                if (haddr_i[9:0] == elc_pkg::LEC_ADDR) begin
                    s_next.rdata = {16'h0000, s_next.lec};
                end else if (haddr_i[9:0] == elc_pkg::PCTL_ADDR) begin
                    s_next.rdata[elc_pkg::PULSE_EN_BIT] = s_next.pulse_en;
                end else if (haddr_i[9:0] == elc_pkg::STAT_ADDR) begin
                    s_next.rdata = {21'h000000, fifo_count, s_reg.pend, s_reg.st,
                                    fifo_in_ready, fifo_out_valid};
                end
            end
        end

        // pulse timer: 200 equal slices per period
        if (s_reg.slice_div == 8'(elc_pkg::SLICE_CYC - 1)) begin
            s_next.slice_div = 8'h00;
            if (s_reg.slice_cnt == 8'(elc_pkg::SLICES - 1)) begin
                s_next.slice_cnt = 8'h00;
            end else begin
                s_next.slice_cnt = s_reg.slice_cnt + 8'h01;
            end
        end else begin
            s_next.slice_div = s_reg.slice_div + 8'h01;
        end

        // frame timer; a snapshot waits in pend until the fifo takes it
        if (tick) begin
            s_next.frm_cnt = 20'h00000;
            if ((p0_ser || p1_ser) && !s_reg.pend) begin
                s_next.pend = 1'b1;
                s_next.snap = {led_p1_i, led_p0_i};
            end
        end else begin
            s_next.frm_cnt = s_reg.frm_cnt + 20'h00001;
        end
        if (s_reg.pend && fifo_in_ready) begin
            s_next.pend = 1'b0;
        end

        // serial shifter
        s_next.half_cnt = half_end ? 4'h0 : s_reg.half_cnt + 4'h1;
        case (s_reg.st)
            elc_pkg::ST_IDLE: begin
                s_next.ser      = '0;
                s_next.half_cnt = 4'h0;
                if (pop) begin
                    s_next.st = elc_pkg::ST_SHIFT;
                    if (rate == elc_pkg::RATE_BASIC) begin
                        s_next.shreg     = {fifo_out.p1, fifo_out.p0};
                        s_next.bits_left = 4'h8;
                    end else begin
                        case (sel)
                            2'h0: s_next.shreg = {fifo_out.p1, fifo_out.p0};
                            2'h1: s_next.shreg = {fifo_out.p1[2:0], fifo_out.p0[2:0], 2'h0};
                            2'h2: s_next.shreg = {fifo_out.p1[1:0], fifo_out.p0[1:0], 4'h0};
                            default: s_next.shreg = {fifo_out.p1[0], fifo_out.p0[0], 6'h00};
                        endcase
                        // two bits per led kept: 8, 6, 4 or 2; three bits so 4 does not wrap
                        s_next.bits_left = {3'h4 - {1'b0, sel}, 1'b0};
                    end
                    s_next.ser.data = s_next.shreg[7];
                end
            end
            elc_pkg::ST_SHIFT: begin
                // data is set up in the low half, sampled on the rising clock
                if (half_end) begin
                    if (!s_reg.ser.clk) begin
                        s_next.ser.clk = 1'b1;
                    end else begin
                        s_next.ser.clk   = 1'b0;
                        s_next.shreg     = {s_reg.shreg[6:0], 1'b0};
                        s_next.bits_left = s_reg.bits_left - 4'h1;
                        s_next.ser.data  = s_reg.shreg[6];
                        if (s_reg.bits_left == 4'h1) begin
                            s_next.st       = elc_pkg::ST_LOAD;
                            s_next.ser.data = 1'b0;
                            s_next.ser.load = 1'b1;
                        end
                    end
                end
            end
            elc_pkg::ST_LOAD: begin
                // one half-bit load strobe latches the shift registers
                if (half_end) begin
                    s_next.ser.load = 1'b0;
                    s_next.st       = elc_pkg::ST_IDLE;
                end
            end
            default: begin
                s_next.st = elc_pkg::ST_IDLE;
            end
        endcase

        // pin muxing: serial group or normal leds, pulsed when enabled
        if (p0_ser) begin
            s_next.p0_out = {1'b0, s_reg.ser};
        end else begin
            s_next.p0_out = led_p0_i & {4{pulse_on || !s_reg.pulse_en}};
        end
        if (p1_ser) begin
            s_next.p1_out = {1'b0, s_reg.ser};
        end else begin
            s_next.p1_out = led_p1_i & {4{pulse_on || !s_reg.pulse_en}};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg          <= '0;
            s_reg.lec      <= elc_pkg::LEC_RST;
            s_reg.pulse_en <= elc_pkg::PCTL_RST;
            s_reg.st       <= elc_pkg::ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_last_bit;
        s_reg.st == elc_pkg::ST_SHIFT && s_reg.bits_left == 4'h1 && s_reg.ser.clk && half_end;
    endsequence
    sequence s_load_strobe;
        s_reg.ser.load && s_reg.st == elc_pkg::ST_LOAD;
    endsequence

    a_duty_clamp: assert property (
        duty_eff <= elc_pkg::DUTY_MAX && (duty <= elc_pkg::DUTY_MAX -> duty_eff == duty))
        else $error("duty setting not clamped to 0..198");
    a_pulse_first: assert property (
        s_reg.slice_cnt == 8'h00 |-> pulse_on)
        else $error("first slice not on");
    a_pulse_last: assert property (
        s_reg.slice_cnt == 8'(elc_pkg::SLICES - 1) |-> !pulse_on)
        else $error("last slice not off");
    a_pulse_step: assert property (
        $fell(pulse_on) && $stable(duty_eff) |-> s_reg.slice_cnt == duty_eff + 8'h01)
        else $error("on-time not duty plus one slices");
    a_slice_len: assert property (
        $changed(s_reg.slice_cnt) |-> s_reg.slice_div == 8'h00 ##1
            s_reg.slice_div == 8'h01 && $stable(s_reg.slice_cnt))
        else $error("slice length wrong");
    a_pulse_gate: assert property (
        !p0_ser && !s_reg.pulse_en |=> led_p0_o == $past(led_p0_i))
        else $error("leds altered with pulsing off");
    a_p0_serial: assert property (
        p0_ser |=> led_p0_o == {1'b0, $past(s_reg.ser)})
        else $error("port 0 pins not serial");
    a_p1_serial: assert property (
        p1_ser |=> led_p1_o == {1'b0, $past(s_reg.ser)})
        else $error("port 1 pins not serial");
    a_frame_rate: assert property (
        tick && $stable(rate) |-> 32'(s_reg.frm_cnt) + 32'd1 == period || $past(tick))
        else $error("frame period does not match rate");
    a_basic_len: assert property (
        pop && rate == elc_pkg::RATE_BASIC |=> s_reg.bits_left == 4'h8)
        else $error("basic stream not eight bits");
    a_select_len: assert property (
        pop && rate != elc_pkg::RATE_BASIC |=>
            s_reg.bits_left == {3'h4 - {1'b0, $past(sel)}, 1'b0})
        else $error("stream length not matching select");
    a_load_follows: assert property (
        s_last_bit |=> s_load_strobe [*5] ##1 s_load_strobe [*5] ##1
            s_reg.st == elc_pkg::ST_IDLE)
        else $error("load strobe missing after last bit");
endmodule : elc_top

// ==== testbench/elc_led_rx.sv ====
// Purpose: far-side model, a serial LED shift register with load latch
// Assumes: pin bit0 data, bit1 shift clock, bit2 load strobe
// Notes:   only listens; frames counted at each load rise
`timescale 1ns/1ps

module elc_led_rx (
    // serial pins of one port
    input  wire logic [3:0] pins_i,
    // captured frame
    output logic     [7:0] frame_o,
    output int             bits_o,
    output int             frames_o,
    output realtime        t_load_o
);
    logic [7:0] shift_reg;
    int         cnt;

    initial begin
        shift_reg = 8'h00;
        cnt       = 0;
        frame_o   = 8'h00;
        bits_o    = 0;
        frames_o  = 0;
        t_load_o  = 0;
    end

    // data is stable at the rising shift clock, it changes at the fall
    always @(posedge pins_i[1]) begin
        shift_reg = {shift_reg[6:0], pins_i[0]};
        cnt++;
    end

    // load latches the shifted bits; stray edges in normal mode are flushed here
    always @(posedge pins_i[2]) begin
        frame_o  = shift_reg;
        bits_o   = cnt;
        cnt      = 0;
        frames_o++;
        t_load_o = $realtime;
    end
endmodule : elc_led_rx

// ==== testbench/led_enhancement_control_tb.sv ====
// Purpose: self-checking bench for the LED enhancement block
// Assumes: zero-wait AHB-Lite slave, shortened frame periods
// Notes:   one pulse period costs 50000 cycles, so only one duty is timed
`timescale 1ns/1ps

module led_enhancement_control_tb;
    localparam int unsigned FRM [0:6] = '{400, 450, 500, 550, 600, 650, 700};
    logic        clk_i, arst_n_i, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  led_p0_i, led_p1_i, led_p0_o, led_p1_o;
    logic [7:0]  rx0_f, rx1_f;
    int          rx0_b, rx1_b, rx0_n, rx1_n, bad_count, checks_done, cyc;
    realtime     rx0_t, rx1_t;

    elc_top #(.FRM_CYC(FRM)) dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hreadyout),
        .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .led_p0_i(led_p0_i), .led_p1_i(led_p1_i), .led_p0_o(led_p0_o), .led_p1_o(led_p1_o));
    elc_led_rx rx0 (.pins_i(led_p0_o), .frame_o(rx0_f), .bits_o(rx0_b), .frames_o(rx0_n),
        .t_load_o(rx0_t));
    elc_led_rx rx1 (.pins_i(led_p1_o), .frame_o(rx1_f), .bits_o(rx1_b), .frames_o(rx1_n),
        .t_load_o(rx1_t));

    // clock, 100 ns period
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // hang guard above the planned run of about 75000 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic fail_msg(input string m);
        bad_count++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask : fail_msg

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) fail_msg($sformatf("value %h expected %h", got, exp));
    endtask : chk_val

    task automatic chk_num(input int got, input int exp);
        checks_done++;
        if (got != exp) fail_msg($sformatf("count %0d expected %0d", got, exp));
    endtask : chk_num

    // one single word transfer; waits on hready in both phases, the hang guard ends a stall
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic wait_ld(input int k, input bit p0);
        int s, n;
        s = p0 ? rx0_n : rx1_n;
        n = 0;
        while ((p0 ? rx0_n : rx1_n) < s + k && n < 3000 * k) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000 * k) fail_msg("no frame");
    endtask : wait_ld

    // reset values, write/read back, refused addresses
    task automatic t_regs();
        ahb(1'b0, 32'(elc_pkg::LEC_ADDR), 32'h0); chk_val(rd, 32'(elc_pkg::LEC_RST));
        ahb(1'b0, 32'(elc_pkg::PCTL_ADDR), 32'h0); chk_val(rd, 32'h0);
        // idle status: fifo empty but ready, shifter idle, nothing pending
        ahb(1'b0, 32'(elc_pkg::STAT_ADDR), 32'h0); chk_val(rd, 32'h0000_0006);
        ahb(1'b1, 32'(elc_pkg::LEC_ADDR), 32'hFFFF_C6AA);
        ahb(1'b0, 32'(elc_pkg::LEC_ADDR), 32'h0); chk_val(rd, 32'h0000_C6AA);
        ahb(1'b1, 32'h0000_0464, 32'h0000_1234);
        ahb(1'b0, 32'(elc_pkg::LEC_ADDR), 32'h0); chk_val(rd, 32'h0000_C6AA);
        ahb(1'b0, 32'h0000_03FC, 32'h0); chk_val(rd, 32'h0);
        chk_val(32'(hresp), 32'h0);
    endtask : t_regs

    // duty 7 over one whole period: (7+1) slices of 250 cycles on
    task automatic t_pulse();
        int on;
        led_p0_i <= 4'hF;
        ahb(1'b1, 32'(elc_pkg::LEC_ADDR), 32'h0000_0700);
        repeat (3) @(negedge clk_i);
        chk_val(32'(led_p0_o), 32'hF);
        ahb(1'b1, 32'(elc_pkg::PCTL_ADDR), 32'h0000_1000);
        // the pins lag the enable by one cycle; skip it so the window is one clean period
        @(negedge clk_i);
        on = 0;
        repeat (50000) begin
            @(negedge clk_i);
            if (led_p0_o === 4'hF) on++;
        end
        chk_num(on, 2000);
        ahb(1'b1, 32'(elc_pkg::PCTL_ADDR), 32'h0);
    endtask : t_pulse

    // every select code on port 1, frame content and bit count
    task automatic t_select();
        int n;
        led_p1_i <= 4'hB;
        led_p0_i <= 4'h6;
        for (int s = 0; s < 4; s++) begin
            n = 4 - s;
            ahb(1'b1, 32'(elc_pkg::LEC_ADDR), 32'h80 | 32'(s << 1));
            wait_ld(3, 1'b0);
            chk_num(rx1_b, 2 * n);
            chk_val(32'(rx1_f) & ((32'h1 << (2 * n)) - 1),
                ((32'hB & ((1 << n) - 1)) << n) | (32'h6 & ((1 << n) - 1)));
        end
    endtask : t_select

    // each rate code: spacing of load strobes; code 7 gives the full basic frame
    task automatic t_rate();
        realtime t0;
        for (int r = 0; r < 8; r++) begin
            ahb(1'b1, 32'(elc_pkg::LEC_ADDR), 32'h86 | 32'(r << 3));
            wait_ld(3, 1'b0);
            t0 = rx1_t;
            wait_ld(1, 1'b0);
            chk_num(int'((rx1_t - t0) / 100.0), int'(FRM[r == 7 ? 0 : r]));
            chk_num(rx1_b, r == 7 ? 8 : 2);
        end
    endtask : t_rate

    // port 0 serial while port 1 stays a plain LED output
    task automatic t_port0();
        ahb(1'b1, 32'(elc_pkg::LEC_ADDR), 32'h0000_0040);
        wait_ld(3, 1'b1);
        chk_val(32'(rx0_f), 32'hB6);
        @(negedge clk_i);
        chk_val(32'(led_p1_o), 32'hB);
    endtask : t_port0

    task automatic finish_test();
        $display("mismatches %0d, checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // reset for 12 cycles, then the scenarios in turn
    initial begin
        bad_count = 0; checks_done = 0; cyc = 0;
        arst_n_i = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; led_p0_i = 4'h0; led_p1_i = 4'h0;
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_pulse();
        t_select();
        t_rate();
        t_port0();
        finish_test();
    end
endmodule : led_enhancement_control_tb
